// ---- rtl/double_speed_clock_select.v ----
// speed-select register and clock-enable generation for core and peripherals
`timescale 1ns/1ps
`include "clk_speed_consts.vh"
// Behaviour
// - standard mode halves crystal before phase generator
// - software can disable halving via register write
// - boot fuse starts device in double speed
// - global bit selects six or twelve periods
// - global bit cleared after reset by default
// - global bit speeds the CPU and peripherals whose own bit is clear
// - peripheral doubles only when its bit cleared
// - double speed bypasses halving divider
// - mode change taken on halved clock rising edge
// - doubled peripheral time base halves, rates double
// - peripheral bit cleared six periods, set twelve
// - peripheral bits ignored while global bit clear
module double_speed_clock_select (
    input  wire       mclk,                  // system clock
    input  wire       srst,                  // synchronous reset
    input  wire       crystal_input,         // one pulse per crystal period
    input  wire       boot_fast_clock_fuse,  // fuse: start in double speed
    input  wire [7:0] sfr_addr,              // special function address
    input  wire [7:0] sfr_wdata,             // write data
    input  wire       sfr_wr,                // write strobe
    input  wire       sfr_rd,                // read strobe
    output reg  [7:0] sfr_rdata,             // read data
    output reg        sfr_rvalid,            // read data valid
    output wire       half_period_mode,      // applied double-speed state
    output wire       cpu_cycle_en,          // one pulse per machine cycle
    output wire [6:0] periph_cycle_en        // one pulse per periph cycle
);
    // ****************************************
    // state codes and decode functions
    // ****************************************
    // one-hot boot sequence codes
    localparam ST_W         = 2;
    localparam ST_LOAD_FUSE = 2'h1;
    localparam ST_RUN       = 2'h2;

    // bus address selects the speed-select register
    function sel_match;
        input [7:0] addr;
        begin
            sel_match = (addr == `SPEED_SEL_ADDR);
        end
    endfunction

    // twelve ticks only when the global and own bit are both set
    function six_periods;
        input global_fast;
        input own_slow;
        begin
            six_periods = !global_fast || !own_slow;
        end
    endfunction

    // ****************************************
    // storage and wiring
    // ****************************************
    // register and boot sequence
    reg  [7:0]               clock_speed_select;
    reg  [7:0]               next_speed_select;
    reg  [ST_W-1:0]          boot_state;
    reg  [ST_W-1:0]          next_boot_state;
    reg  [7:0]               next_rdata;
    reg                      next_rvalid;

    // halving divider and applied mode
    reg                      half_div;
    reg                      next_half_div;
    reg                      applied_fast;
    reg                      next_applied_fast;
    wire                     half_rise;
    wire                     core_tick;

    // peripheral count selects
    wire [`PERIPH_COUNT-1:0] periph_six;

    // ****************************************
    // boot sequence: one cycle to pick up the fuse
    // ****************************************
    // the register leaves reset at zero and takes the fuse one edge later
    always @* begin
        case (boot_state)
            ST_LOAD_FUSE: begin
                next_boot_state = ST_RUN;
            end
            ST_RUN: begin
                next_boot_state = ST_RUN;
            end
            default: begin
                next_boot_state = ST_LOAD_FUSE;
            end
        endcase
    end

    always @(posedge mclk) begin
        if (srst) begin
            boot_state <= ST_LOAD_FUSE;
        end else begin
            boot_state <= next_boot_state;
        end
    end

    // ****************************************
    // speed-select register
    // ****************************************
    // register bits apply at once; only the global bit waits for the edge
    always @* begin
        next_speed_select = clock_speed_select;
        case (boot_state)
            ST_LOAD_FUSE: begin
                // a bus write in this cycle is dropped
                next_speed_select[`BIT_HALF_PERIOD] =
                    boot_fast_clock_fuse;
            end
            ST_RUN: begin
                if (sfr_wr && sel_match(sfr_addr)) begin
                    next_speed_select = sfr_wdata;
                end
            end
            default: begin
                next_speed_select = `SPEED_SEL_RESET;
            end
        endcase
    end

    always @(posedge mclk) begin
        if (srst) begin
            clock_speed_select <= `SPEED_SEL_RESET;
        end else begin
            clock_speed_select <= next_speed_select;
        end
    end

    // ****************************************
    // read path
    // ****************************************
    // data and valid answer one cycle after the strobe
    always @* begin
        next_rvalid = sfr_rd;
        if (sfr_rd && sel_match(sfr_addr)) begin
            next_rdata = clock_speed_select;
        end else begin
            // unmapped addresses read as zero
            next_rdata = 8'h00;
        end
    end

    always @(posedge mclk) begin
        if (srst) begin
            sfr_rdata  <= 8'h00;
            sfr_rvalid <= 1'h0;
        end else begin
            sfr_rdata  <= next_rdata;
            sfr_rvalid <= next_rvalid;
        end
    end

    // ****************************************
    // input halving and glitch-free switch
    // ****************************************
    always @* begin
        next_half_div     = half_div;
        next_applied_fast = applied_fast;
        if (crystal_input) begin
            next_half_div = ~half_div;
            if (!half_div) begin
                // mode taken only as the halved clock rises
                next_applied_fast =
                    clock_speed_select[`BIT_HALF_PERIOD];
            end
        end
    end

    always @(posedge mclk) begin
        if (srst) begin
            half_div     <= 1'h0;
            applied_fast <= 1'h0;
        end else begin
            half_div     <= next_half_div;
            applied_fast <= next_applied_fast;
        end
    end

    assign half_rise        = crystal_input && !half_div;
    assign half_period_mode = applied_fast;
    // fast: every crystal period; standard: every other one
    assign core_tick = applied_fast ? crystal_input : half_rise;

    // ****************************************
    // cycle generation
    // ****************************************
    // counters keep running across a switch; only the tick source and
    // the count change, so no enable pulse is ever split
    rate_divider u_cpu (
        .mclk     (mclk),
        .srst     (srst),
        .tick_in  (core_tick),
        .fast     (1'b1),
        .cycle_en (cpu_cycle_en)
    );

    // enable bit order: 0 timer zero, 1 timer one, 2 timer two,
    // 3 serial, 4 counter array, 5 watchdog, 6 fieldbus
    genvar i;
    generate
        for (i = 0; i < `PERIPH_COUNT; i = i + 1) begin : g_periph
            // global clear: six halved ticks; own bit clear: six
            // undivided ticks; own bit set: twelve undivided ticks
            assign periph_six[i] = six_periods(
                applied_fast,
                clock_speed_select[`BIT_TIMER_ZERO + i]);
            rate_divider u_div (
                .mclk     (mclk),
                .srst     (srst),
                .tick_in  (core_tick),
                .fast     (periph_six[i]),
                .cycle_en (periph_cycle_en[i])
            );
        end
    endgenerate
endmodule // double_speed_clock_select

// ---- rtl/clk_speed_consts.vh ----
// constants for the double-speed clock select block
`ifndef CLK_SPEED_CONSTS_VH
`define CLK_SPEED_CONSTS_VH
`define SPEED_SEL_ADDR      8'h8f
`define SPEED_SEL_RESET     8'h00
`define BIT_HALF_PERIOD     0
`define BIT_TIMER_ZERO      1
`define BIT_TIMER_ONE       2
`define BIT_TIMER_TWO       3
`define BIT_SERIAL          4
`define BIT_COUNTER_ARRAY   5
`define BIT_WATCHDOG        6
`define BIT_FIELDBUS        7
`define PERIPH_COUNT        7
`define PERIODS_FAST        4'h6
`define PERIODS_STD         4'hc
`define PHASE_CNT_W         4
`endif

// ---- rtl/rate_divider.v ----
// counts clock enables and emits one pulse per machine or peripheral cycle
`timescale 1ns/1ps
`include "clk_speed_consts.vh"
module rate_divider (
    input  wire       mclk,      // system clock
    input  wire       srst,      // synchronous reset
    input  wire       tick_in,   // enable pulse of the source rate
    input  wire       fast,      // 1: 6 periods per cycle, 0: 12
    output reg        cycle_en   // one pulse per cycle
);
    reg [`PHASE_CNT_W-1:0] count;
    wire [`PHASE_CNT_W-1:0] limit;

    assign limit = fast ? `PERIODS_FAST : `PERIODS_STD;

    always @(posedge mclk) begin
        if (srst) begin
            count    <= {`PHASE_CNT_W{1'b0}};
            cycle_en <= 1'b0;
        end else begin
            cycle_en <= 1'b0;
            if (tick_in) begin
                if (count >= limit - 4'h1) begin
                    count    <= {`PHASE_CNT_W{1'b0}};
                    cycle_en <= 1'b1;
                end else begin
                    count <= count + 4'h1;
                end
            end
        end
    end
endmodule // rate_divider

// ---- test/clk_sel_assertions.sv ----
// assertion checker for the double-speed clock select block
`timescale 1ns/1ps
module clk_sel_checker (
    input wire       mclk,             // clock
    input wire       srst,             // reset
    input wire       crystal_input,    // crystal tick
    input wire [7:0] sfr_addr,         // address
    input wire [7:0] sfr_wdata,        // write data
    input wire       sfr_wr,           // write strobe
    input wire       sfr_rd,           // read strobe
    input wire [7:0] sfr_rdata,        // read data
    input wire       sfr_rvalid,       // read valid
    input wire       half_period_mode, // applied mode
    input wire       cpu_cycle_en,     // cpu pulse
    input wire [6:0] periph_cycle_en   // peripheral pulses
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);
    sequence s_wr; sfr_wr && sfr_addr == 8'h8f; endsequence
    sequence s_rd; sfr_rd && sfr_addr == 8'h8f; endsequence
    property p_wr_rd;
        s_wr ##1 !sfr_wr ##1 s_rd |=> sfr_rdata == $past(sfr_wdata, 3);
    endproperty
    property p_other; sfr_rd && sfr_addr != 8'h8f |=> sfr_rdata == 8'h00; endproperty
    property p_rv; sfr_rd |=> sfr_rvalid; endproperty
    property p_no_rv; !sfr_rd |=> !sfr_rvalid; endproperty
    property p_sync; $changed(half_period_mode) |-> $past(crystal_input); endproperty
    property p_cpu; cpu_cycle_en |=> !cpu_cycle_en [*5]; endproperty
    property p_t0; periph_cycle_en[0] |=> !periph_cycle_en[0] [*8]; endproperty
    property p_fb; periph_cycle_en[6] |=> !periph_cycle_en[6] [*8]; endproperty
    a_wr_rd: assert property (p_wr_rd) else $error("readback wrong");
    a_other: assert property (p_other) else $error("unmapped read");
    a_rv: assert property (p_rv) else $error("no rvalid");
    a_no_rv: assert property (p_no_rv) else $error("stray rvalid");
    a_sync: assert property (p_sync) else $error("mode off tick");
    a_cpu: assert property (p_cpu) else $error("cpu pulse gap");
    a_t0: assert property (p_t0) else $error("timer pulse gap");
    a_fb: assert property (p_fb) else $error("fieldbus gap");
endmodule // clk_sel_checker

// ---- test/testbench.sv ----
// self-checking bench for the double-speed clock select block
`timescale 1ns/1ps
module testbench;
    reg        mclk = 0, srst = 1, xtal = 0, fuse = 0, wr = 0, rd = 0;
    reg  [7:0] addr = 8'h00, wdata = 8'h00;
    wire [7:0] rdata;
    wire       rvalid, mode, cpu;
    wire [6:0] per;
    wire [7:0] ev = {cpu, per};
    integer    num_errors = 0, n_checks = 0, t, n, k;
    always #4 mclk = ~mclk;
    // one crystal tick every second clock
    always @(negedge mclk) xtal <= ~xtal & ~srst;
    double_speed_clock_select i_double_speed_clock_select (.mclk(mclk),
        .srst(srst), .crystal_input(xtal), .boot_fast_clock_fuse(fuse),
        .sfr_addr(addr), .sfr_wdata(wdata), .sfr_wr(wr), .sfr_rd(rd),
        .sfr_rdata(rdata), .sfr_rvalid(rvalid), .half_period_mode(mode),
        .cpu_cycle_en(cpu), .periph_cycle_en(per));
    task conclude;
        begin
            if (num_errors == 0 && n_checks > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask
    task chk(input [47:0] nm, input [7:0] e, input [7:0] s);
        begin
            n_checks = n_checks + 1;
            if (s !== e) begin
                num_errors = num_errors + 1;
                $display("mismatch %0s exp %h got %h", nm, e, s);
            end
        end
    endtask
    task put(input [7:0] d);
        begin
            @(negedge mclk) wr = 1; addr = 8'h8f; wdata = d;
            @(negedge mclk) wr = 0;
        end
    endtask
    task get(input [7:0] a, input [7:0] e);
        begin
            @(negedge mclk) rd = 1; addr = a;
            @(negedge mclk) rd = 0;
            chk("rvalid", 8'h01, {7'h00, rvalid});
            chk("rdata", e, rdata);
        end
    endtask
    // cycles between the second and third pulse of one enable
    task gap(input integer i, input [7:0] e);
        begin
            n = 0; t = 0; k = 0;
            while (n < 3 && k < 400) begin
                @(negedge mclk) k = k + 1;
                if (n == 2) t = t + 1;
                if (ev[i] === 1'b1) n = n + 1;
            end
            if (n < 3) begin
                num_errors = num_errors + 1;
                $display("mismatch gap pulses exp 3 got %0d", n);
                conclude;
            end
            chk("gap", e, t[7:0]);
        end
    endtask
    initial begin
        repeat (12) @(negedge mclk); srst <= 1'b0;
        @(negedge mclk);
        get(8'h8f, 8'h00);
        get(8'h8e, 8'h00);
        chk("mode", 8'h00, {7'h00, mode});
        gap(7, 24);
        gap(0, 24);
        put(8'hfe); gap(6, 24);
        put(8'h81); get(8'h8f, 8'h81);
        gap(7, 12);
        gap(0, 12);
        gap(6, 24);
        gap(3, 12);
        put(8'h00); gap(7, 24);
        fuse = 1; srst <= 1'b1; repeat (12) @(negedge mclk); srst <= 1'b0;
        repeat (4) @(negedge mclk);
        chk("mode", 8'h01, {7'h00, mode});
        gap(7, 12);
        conclude;
    end
endmodule // testbench
bind double_speed_clock_select clk_sel_checker i_clk_sel_checker (
    .mclk(mclk), .srst(srst), .crystal_input(crystal_input),
    .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .sfr_rvalid(sfr_rvalid),
    .half_period_mode(half_period_mode), .cpu_cycle_en(cpu_cycle_en),
    .periph_cycle_en(periph_cycle_en));
